// ---- core/internal_osc_clock_select.sv ----
module internal_osc_clock_select
   import osc_pkg::*;
#(
   parameter int LOOP_START_CYC = LOOP_START_DEF,
   parameter int HF_LOCK_CYC = 64,
   parameter int HF_STABLE_CYC = 256
) (
   // Clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // Register port
   input wire logic [7:0] regAddr,
   input wire logic [7:0] regWrData,
   input wire logic regWr,
   input wire logic regRd,
   output logic [7:0] regRdData,
   // Configuration word
   input wire logic [2:0] cfgOscSelect,
   input wire logic cfgLoopEnable,
   input wire logic clkOutCfg,
   input wire logic wdtEnable,
   input wire logic fsmEnable,
   // Oscillators, indexed by source
   input wire logic [3:0] oscRaw,
   output logic [3:0] oscEn,
   output logic [5:0] oscTrim,
   // System clock
   output logic sysClk,
   output logic intActive,
   output logic lfTimeBase,
   // Oscillator pins
   input wire pin_t gpioOsc1,
   input wire pin_t gpioOsc2,
   input wire logic oscInLevel,
   input wire logic oscOutLevel,
   output pin_t oscInPin,
   output pin_t oscOutPin,
   output logic [1:0] pinInData
);

   // ==========================================================
   // Registers
   typedef enum logic [1:0] {
      ST_RUN = 2'b00,
      ST_START = 2'b01,
      ST_WAIT_FALL = 2'b11,
      ST_HOLD = 2'b10
   } state_t;

   logic [3:0] freqSel_q;
   logic [1:0] srcSel_q;
   logic swLoop_q;
   logic [5:0] trim_q;
   state_t state_q, state_d;
   sel_t cur_q, pend_q, target;
   logic [1:0] syncCnt_q;
   logic intMode, loopUse;
   logic [3:0] need, ready, rawPrev_q, rise;
   logic [RDY_W-1:0] rdyCnt_q [4];
   logic [DIV_W-1:0] divCnt_q [4];
   logic curLevel, newLevel, curPrev_q, newPrev_q;
   logic curFall, newRise, sysClk_d;
   logic [15:0] lockCnt_q;
   status_t status_q;

   // Start-up delay for each source
   function automatic logic [RDY_W-1:0] startLim(input int i);
      case (i)
         SRC_LF: return RDY_W'(LF_START_CYC);
         SRC_LOOP: return RDY_W'(LOOP_START_CYC);
         default: return RDY_W'(OSC_START_CYC);
      endcase
   endfunction

   // Postscaled level of a selection
   function automatic logic divLevel(input sel_t s);
      logic [DIV_W-1:0] c;
      c = divCnt_q[s.src];
      if (s.exp == 4'h0) begin
         return oscRaw[s.src];
      end
      return c[s.exp - 4'h1];
   endfunction

   // ==========================================================
   // Register writes; reset values of the control fields
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         freqSel_q <= FREQ_RESET;
         srcSel_q <= SCS_RESET;
         swLoop_q <= 1'b0;
         trim_q <= TRIM_RESET;
      end else if (regWr) begin
         if (regAddr == ADDR_CTRL) begin
            freqSel_q <= regWrData[CTRL_FREQ_LSB +: 4];
            srcSel_q <= regWrData[CTRL_SCS_LSB +: 2];
            swLoop_q <= regWrData[CTRL_LOOP_BIT];
         end
         if (regAddr == ADDR_TRIM) begin
            trim_q <= regWrData[5:0];
         end
      end
   end

   // Trim goes straight to the MF reference; HF follows it
   // through the loop. LF has no trim input at all, and no
   // flag marks the end of the drift.
   assign oscTrim = trim_q;

   // Register reads, data valid only in the next cycle
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         regRdData <= 8'h00;
      end else if (regRd) begin
         case (regAddr)
            ADDR_CTRL: regRdData <= {swLoop_q, freqSel_q,
                                     1'b0, srcSel_q};
            ADDR_STATUS: regRdData <= status_q;
            ADDR_TRIM: regRdData <= {2'b00, trim_q};
            default: regRdData <= 8'h00;
         endcase
      end else begin
         regRdData <= 8'h00;
      end
   end

   // ==========================================================
   // Source decode
   // Secondary (01) and external default leave internal mode
   assign intMode = srcSel_q[1] ||
      (srcSel_q == SCS_DEFAULT &&
       cfgOscSelect == FOSC_INTERNAL_BLOCK_CLK);
   // Loop only via the default path; config bit wins
   assign loopUse = cfgOscSelect == FOSC_INTERNAL_BLOCK_CLK &&
      srcSel_q == SCS_DEFAULT &&
      freqSel_q == FREQ_32M &&
      (cfgLoopEnable || swLoop_q);

   // Code 0 and 1 land on LF via the decode table
   always_comb begin
      target = decodeFreq(freqSel_q);
      if (loopUse) begin
         target = '{SRC_LOOP, 4'h0};
      end
   end

   // ==========================================================
   // Oscillator enables: unused sources are powered down
   always_comb begin
      need = 4'h0;
      if (intMode) begin
         need[cur_q.src] = 1'b1;
         need[pend_q.src] = 1'b1;
      end
      // Loop rides on HF, HF rides on MF
      need[SRC_HF] = need[SRC_HF] | need[SRC_LOOP];
      need[SRC_MF] = need[SRC_MF] | need[SRC_HF];
      // Timers keep LF alive regardless of selection
      need[SRC_LF] = need[SRC_LF] |
         wdtEnable | fsmEnable;
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         oscEn <= 4'h0;
      end else begin
         oscEn <= need;
      end
   end

   // ==========================================================
   // Per-source start-up timer and postscaler
   genvar gi;
   generate
      for (gi = 0; gi < 4; gi++) begin : g_src
         // Ready once the start-up delay has run
         always_ff @(posedge clk) begin
            if (!rst_n || !oscEn[gi]) begin
               rdyCnt_q[gi] <= '0;
            end else if (rdyCnt_q[gi] != startLim(gi)) begin
               rdyCnt_q[gi] <= rdyCnt_q[gi] + 1'b1;
            end
         end
         assign ready[gi] = oscEn[gi] &&
            rdyCnt_q[gi] == startLim(gi);
         assign rise[gi] = oscRaw[gi] & ~rawPrev_q[gi];

         // Free-running divider per source
         always_ff @(posedge clk) begin
            if (!rst_n) begin
               divCnt_q[gi] <= '0;
            end else if (rise[gi]) begin
               divCnt_q[gi] <= divCnt_q[gi] + 1'b1;
            end
         end
      end
   endgenerate

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         rawPrev_q <= 4'h0;
      end else begin
         rawPrev_q <= oscRaw;
      end
   end

   // ==========================================================
   // Glitch-free switch
   // Process, not assign: the lookup reads dividers and raw levels
   always_comb begin
      curLevel = divLevel(cur_q);
      newLevel = divLevel(pend_q);
   end
   assign curFall = curPrev_q & ~curLevel;
   assign newRise = ~newPrev_q & newLevel;

   always_comb begin
      state_d = state_q;
      case (state_q)
         ST_RUN: begin
            if (intMode && target != cur_q) begin
               state_d = ST_START;
            end
         end
         // Same source is already ready: one cycle only
         ST_START: begin
            if (ready[pend_q.src]) begin
               state_d = ST_WAIT_FALL;
            end
         end
         ST_WAIT_FALL: begin
            if (curFall) begin
               state_d = ST_HOLD;
            end
         end
         ST_HOLD: begin
            if (newRise && syncCnt_q == 2'(SYNC_EDGES - 1)) begin
               state_d = ST_RUN;
            end
         end
         default: state_d = ST_RUN;
      endcase
   end

   // State and selections; reset starts on the 500 kHz code
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         state_q <= ST_RUN;
         cur_q <= decodeFreq(FREQ_RESET);
         pend_q <= decodeFreq(FREQ_RESET);
      end else begin
         state_q <= state_d;
         if (state_q == ST_RUN && state_d == ST_START) begin
            pend_q <= target;
         end
         if (state_q == ST_HOLD && state_d == ST_RUN) begin
            cur_q <= pend_q;
         end
      end
   end

   // New-clock edges counted while held low
   always_ff @(posedge clk) begin
      if (!rst_n || state_q != ST_HOLD) begin
         syncCnt_q <= 2'h0;
      end else if (newRise) begin
         syncCnt_q <= syncCnt_q + 2'h1;
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         curPrev_q <= 1'b0;
         newPrev_q <= 1'b0;
      end else begin
         curPrev_q <= curLevel;
         newPrev_q <= newLevel;
      end
   end

   // Output held low across the hand-over, so no runt pulse
   always_comb begin
      sysClk_d = curLevel;
      if (state_q == ST_HOLD) begin
         sysClk_d = (state_d == ST_RUN) ? newLevel : 1'b0;
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         sysClk <= 1'b0;
         intActive <= 1'b0;
         lfTimeBase <= 1'b0;
      end else begin
         sysClk <= sysClk_d;
         intActive <= intMode;
         lfTimeBase <= rise[SRC_LF];
      end
   end

   // ==========================================================
   // Status flags
   always_ff @(posedge clk) begin
      if (!rst_n || !ready[SRC_HF]) begin
         lockCnt_q <= 16'h0000;
      end else if (lockCnt_q != 16'(HF_STABLE_CYC)) begin
         lockCnt_q <= lockCnt_q + 16'h0001;
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         status_q <= '0;
      end else begin
         status_q.lfReady <= ready[SRC_LF];
         status_q.mfReady <= ready[SRC_MF];
         status_q.hfReady <= ready[SRC_HF];
         status_q.hfLocked <= ready[SRC_HF] &&
            lockCnt_q >= 16'(HF_LOCK_CYC);
         status_q.hfStable <= ready[SRC_HF] &&
            lockCnt_q >= 16'(HF_STABLE_CYC);
         status_q.loopReady <= ready[SRC_LOOP] &&
            cur_q.src == SRC_LOOP;
         status_q.switchBusy <= state_d != ST_RUN;
         status_q.intActive <= intMode;
      end
   end

   // ==========================================================
   // Pins: both released outside internal mode
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         oscInPin <= '0;
         oscOutPin <= '0;
         pinInData <= 2'h0;
      end else begin
         pinInData <= {oscOutLevel, oscInLevel};
         oscInPin <= intMode ? gpioOsc1 : '0;
         if (!intMode) begin
            oscOutPin <= '0;
         end else if (clkOutCfg) begin
            oscOutPin <= '{sysClk_d, 1'b1};
         end else begin
            oscOutPin <= gpioOsc2;
         end
      end
   end

   // ==========================================================
   // Checks
   AST_RESET_FREQ: assert property (
      @(posedge clk) !rst_n ##1 rst_n |->
         freqSel_q == FREQ_RESET && srcSel_q == SCS_RESET)
      else $error("reset frequency or source wrong");

   AST_HOLD_LOW: assert property (
      @(posedge clk) disable iff (!rst_n)
      state_q == ST_HOLD |-> !sysClk)
      else $error("system clock not held low");

   AST_FALL_TO_HOLD: assert property (
      @(posedge clk) disable iff (!rst_n)
      state_q == ST_WAIT_FALL && curFall |=> state_q == ST_HOLD)
      else $error("falling edge not taken");

   AST_LOOP_GATE: assert property (
      @(posedge clk) disable iff (!rst_n)
      pend_q.src == SRC_LOOP && state_q == ST_START &&
      $past(state_q) == ST_RUN |->
         $past(cfgOscSelect) == FOSC_INTERNAL_BLOCK_CLK &&
         $past(srcSel_q) == SCS_DEFAULT &&
         $past(freqSel_q) == FREQ_32M &&
         ($past(cfgLoopEnable) || $past(swLoop_q)))
      else $error("loop chosen without its conditions");

   AST_CFG_LOOP_WINS: assert property (
      @(posedge clk) disable iff (!rst_n)
      state_q == ST_START && $past(state_q) == ST_RUN &&
      $past(cfgLoopEnable) && !$past(swLoop_q) &&
      $past(cfgOscSelect) == FOSC_INTERNAL_BLOCK_CLK &&
      $past(srcSel_q) == SCS_DEFAULT &&
      $past(freqSel_q) == FREQ_32M |->
         pend_q.src == SRC_LOOP)
      else $error("config loop bit ignored");

   AST_LF_KEEP: assert property (
      @(posedge clk) disable iff (!rst_n)
      $past(rst_n) && $stable(wdtEnable || fsmEnable) &&
      (wdtEnable || fsmEnable) |-> oscEn[SRC_LF])
      else $error("LF off while watchdog or monitor enabled");

   AST_SAME_SRC: assert property (
      @(posedge clk) disable iff (!rst_n)
      state_q == ST_START && ready[pend_q.src] |=>
         state_q == ST_WAIT_FALL)
      else $error("start-up delay on a ready source");

   AST_SWITCH_DONE: assert property (
      @(posedge clk) disable iff (!rst_n)
      state_q == ST_HOLD ##1 state_q == ST_RUN |->
         cur_q == $past(pend_q))
      else $error("new selection not active after switch");

   AST_CLKOUT: assert property (
      @(posedge clk) disable iff (!rst_n)
      intActive && $past(clkOutCfg) |->
         oscOutPin.oe && oscOutPin.o == sysClk)
      else $error("clock out not on second pin");

   AST_HF_FLAGS: assert property (
      @(posedge clk) disable iff (!rst_n)
      (status_q.hfStable |-> status_q.hfLocked) and
      (status_q.hfLocked |-> status_q.hfReady))
      else $error("HF flag order broken");

endmodule

// ---- include/osc_pkg.sv ----
package osc_pkg;

   // ==========================================================
   // Timing
   localparam int CLK_PERIOD_NS = 8;
   localparam int OSC_START_NS = 2000;
   localparam int OSC_START_CYC =
      (OSC_START_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int LOOP_START_NS = 2000000;
   localparam int LOOP_START_DEF =
      (LOOP_START_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int LF_START_CYC = 2;
   localparam int SYNC_EDGES = 2;
   localparam int RDY_W = 18;
   localparam int DIV_W = 9;

   // ==========================================================
   // Register map (byte addresses) and fields
   localparam logic [7:0] ADDR_CTRL = 8'h00;
   localparam logic [7:0] ADDR_STATUS = 8'h04;
   localparam logic [7:0] ADDR_TRIM = 8'h08;
   localparam int CTRL_SCS_LSB = 0;
   localparam int CTRL_FREQ_LSB = 3;
   localparam int CTRL_LOOP_BIT = 7;
   localparam logic [3:0] FREQ_RESET = 4'h7;
   localparam logic [3:0] FREQ_32M = 4'hE;
   localparam logic [1:0] SCS_RESET = 2'h0;
   localparam logic [1:0] SCS_DEFAULT = 2'h0;
   localparam logic [5:0] TRIM_RESET = 6'h00;
   localparam logic [2:0] FOSC_INTERNAL_BLOCK_CLK = 3'h4;

   // ==========================================================
   // Types
   typedef enum logic [1:0] {
      SRC_LF = 2'h0,
      SRC_MF = 2'h1,
      SRC_HF = 2'h2,
      SRC_LOOP = 2'h3
   } src_t;

   typedef struct packed {
      src_t src;
      logic [3:0] exp;
   } sel_t;

   typedef struct packed {
      logic o;
      logic oe;
   } pin_t;

   typedef struct packed {
      logic intActive;
      logic switchBusy;
      logic loopReady;
      logic hfStable;
      logic hfLocked;
      logic hfReady;
      logic mfReady;
      logic lfReady;
   } status_t;

   // Frequency code to source and postscale exponent.
   // Several codes reach one frequency from two sources.
   function automatic sel_t decodeFreq(input logic [3:0] code);
      sel_t s;
      s.src = SRC_HF;
      s.exp = 4'h0;
      case (code)
         4'h0, 4'h1: s = '{SRC_LF, 4'h0};
         4'h2: s = '{SRC_MF, 4'h4};
         4'h3: s = '{SRC_HF, 4'h9};
         4'h4: s = '{SRC_HF, 4'h8};
         4'h5: s = '{SRC_HF, 4'h7};
         4'h6: s = '{SRC_HF, 4'h6};
         4'h7: s = '{SRC_MF, 4'h0};
         4'h8: s = '{SRC_MF, 4'h2};
         4'h9: s = '{SRC_MF, 4'h1};
         4'hA: s = '{SRC_HF, 4'h5};
         4'hB: s = '{SRC_HF, 4'h4};
         4'hC: s = '{SRC_HF, 4'h3};
         4'hD: s = '{SRC_HF, 4'h2};
         4'hE: s = '{SRC_HF, 4'h1};
         default: s = '{SRC_HF, 4'h0};
      endcase
      return s;
   endfunction

endpackage

// ---- sim/internal_osc_clock_select_tb.sv ----
module internal_osc_clock_select_tb
   import osc_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;

   // ==========================================================
   // Signals
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic [7:0] regAddr = 8'h00;
   logic [7:0] regWrData = 8'h00;
   logic regWr = 1'b0;
   logic regRd = 1'b0;
   logic [7:0] regRdData;
   logic [2:0] cfgOscSelect = FOSC_INTERNAL_BLOCK_CLK;
   logic cfgLoopEnable = 1'b0;
   logic clkOutCfg = 1'b0;
   logic wdtEnable = 1'b0;
   logic fsmEnable = 1'b0;
   logic [3:0] oscRaw = 4'h0;
   logic [3:0] oscEn;
   logic [5:0] oscTrim;
   logic sysClk;
   logic intActive;
   logic lfTimeBase;
   pin_t gpioOsc1 = '0;
   pin_t gpioOsc2 = '0;
   logic oscInLevel = 1'b0;
   logic oscOutLevel = 1'b0;
   pin_t oscInPin;
   pin_t oscOutPin;
   logic [1:0] pinInData;
   int failCount = 0;
   int checkCount = 0;
   int halfPer [4] = '{32, 8, 2, 1};
   int oscCnt [4] = '{0, 0, 0, 0};
   logic [7:0] rdVal;
   int n;

   // ==========================================================
   // Clock, 8 ns period
   always #4 clk = ~clk;

   // Short start-up and lock counts keep the run brief
   internal_osc_clock_select #(
      .LOOP_START_CYC(20),
      .HF_LOCK_CYC(16),
      .HF_STABLE_CYC(32)
   ) internal_osc_clock_select_i (
      .clk(clk), .rst_n(rst_n),
      .regAddr(regAddr), .regWrData(regWrData), .regWr(regWr),
      .regRd(regRd), .regRdData(regRdData),
      .cfgOscSelect(cfgOscSelect), .cfgLoopEnable(cfgLoopEnable),
      .clkOutCfg(clkOutCfg), .wdtEnable(wdtEnable),
      .fsmEnable(fsmEnable),
      .oscRaw(oscRaw), .oscEn(oscEn), .oscTrim(oscTrim),
      .sysClk(sysClk), .intActive(intActive), .lfTimeBase(lfTimeBase),
      .gpioOsc1(gpioOsc1), .gpioOsc2(gpioOsc2),
      .oscInLevel(oscInLevel), .oscOutLevel(oscOutLevel),
      .oscInPin(oscInPin), .oscOutPin(oscOutPin),
      .pinInData(pinInData)
   );

   // Oscillators run only while enabled; a stopped one stands low
   always @(posedge clk) begin
      for (int i = 0; i < 4; i++) begin
         if (oscEn[i] === 1'b1) begin
            if (oscCnt[i] + 1 >= halfPer[i]) begin
               oscCnt[i] <= 0;
               oscRaw[i] <= ~oscRaw[i];
            end else begin
               oscCnt[i] <= oscCnt[i] + 1;
            end
         end else begin
            oscCnt[i] <= 0;
            oscRaw[i] <= 1'b0;
         end
      end
   end

   // ==========================================================
   // Tasks
   task automatic giveVerdict();
      $display("checks %0d mismatches %0d", checkCount, failCount);
      if (failCount == 0 && checkCount > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask

   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      checkCount++;
      if (got !== exp) begin
         failCount++;
         $display("CHECK FAILED at %0t got %h expected %h",
            $time, got, exp);
      end
   endtask

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk);
      regAddr <= a;
      regWrData <= d;
      regWr <= 1'b1;
      @(posedge clk);
      regWr <= 1'b0;
   endtask

   // Data stands only in the cycle after the strobe
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(posedge clk);
      regAddr <= a;
      regRd <= 1'b1;
      @(posedge clk);
      regRd <= 1'b0;
      #1;
      d = regRdData;
   endtask

   // Poll one status bit under a bounded count
   task automatic waitStat(input int idx, input logic val);
      logic [7:0] s;
      s = 8'h00;
      for (int k = 0; k < 1000; k++) begin
         rd(ADDR_STATUS, s);
         if (s[idx] === val) begin
            break;
         end
      end
      chk({7'h00, s[idx]}, {7'h00, val});
      if (s[idx] !== val) begin
         giveVerdict();
      end
   endtask

   // Count level changes of the system clock over a window
   task automatic countClk(input int cyc, output int cnt);
      logic prev;
      cnt = 0;
      prev = sysClk;
      repeat (cyc) begin
         @(posedge clk);
         #1;
         if (sysClk !== prev) begin
            cnt++;
         end
         prev = sysClk;
      end
   endtask

   task automatic endTest(input string name);
      $display("test %s finished, mismatches so far %0d", name, failCount);
   endtask

   // ==========================================================
   // Hang guard
   initial begin
      #(8 * 90000);
      failCount++;
      $display("CHECK FAILED at %0t got %h expected %h", $time, 1, 0);
      giveVerdict();
   end

   // ==========================================================
   // Main sequence
   initial begin
      repeat (3) @(posedge clk);
      rst_n <= 1'b1;
      // Reset values and bus behaviour
      rd(ADDR_CTRL, rdVal);
      chk(rdVal, 8'h38);
      @(posedge clk);
      #1;
      chk(regRdData, 8'h00);
      rd(ADDR_TRIM, rdVal);
      chk(rdVal, 8'h00);
      rd(8'h0C, rdVal);
      chk(rdVal, 8'h00);
      chk({7'h00, intActive}, 8'h01);
      waitStat(1, 1'b1);
      endTest("reset");

      // Trim range ends, two writes one idle cycle apart
      wr(ADDR_TRIM, 8'h1F);
      wr(ADDR_TRIM, 8'h1F);
      rd(ADDR_TRIM, rdVal);
      chk(rdVal, 8'h1F);
      chk({2'h0, oscTrim}, 8'h1F);
      wr(ADDR_TRIM, 8'hE0);
      rd(ADDR_TRIM, rdVal);
      chk(rdVal, 8'h20);
      chk({2'h0, oscTrim}, 8'h20);
      endTest("trim");

      // Move to the high-frequency source, full rate
      wr(ADDR_CTRL, 8'hFC);
      rd(ADDR_CTRL, rdVal);
      chk(rdVal, 8'hF8);
      waitStat(2, 1'b1);
      waitStat(6, 1'b0);
      waitStat(4, 1'b1);
      rd(ADDR_STATUS, rdVal);
      chk({7'h00, rdVal[3]}, 8'h01);
      chk({7'h00, rdVal[5]}, 8'h00);
      chk({6'h00, oscEn[2:1]}, 8'h03);
      countClk(64, n);
      chk({7'h00, 1'(n >= 16)}, 8'h01);
      endTest("hf");

      // Loop path: software bit, source select, config override
      wr(ADDR_CTRL, 8'hF0);
      waitStat(5, 1'b1);
      wr(ADDR_CTRL, 8'h72);
      waitStat(5, 1'b0);
      @(posedge clk);
      cfgLoopEnable <= 1'b1;
      wr(ADDR_CTRL, 8'h70);
      waitStat(5, 1'b1);
      @(posedge clk);
      cfgLoopEnable <= 1'b0;
      waitStat(5, 1'b0);
      endTest("loop");

      // Low-frequency selection and keep-alive
      wr(ADDR_CTRL, 8'h02);
      waitStat(0, 1'b1);
      waitStat(6, 1'b0);
      chk({7'h00, oscEn[0]}, 8'h01);
      n = 0;
      repeat (200) begin
         @(posedge clk);
         #1;
         if (lfTimeBase === 1'b1) begin
            n++;
         end
      end
      chk({7'h00, 1'(n >= 1)}, 8'h01);
      @(posedge clk);
      wdtEnable <= 1'b1;
      wr(ADDR_CTRL, 8'h3A);
      // MF was off, so its start-up delay keeps the switch busy
      repeat (100) @(posedge clk);
      rd(ADDR_STATUS, rdVal);
      chk({7'h00, rdVal[6]}, 8'h01);
      waitStat(6, 1'b0);
      chk({7'h00, oscEn[0]}, 8'h01);
      // Same source: done well inside one start-up delay
      wr(ADDR_CTRL, 8'h4A);
      repeat (150) @(posedge clk);
      rd(ADDR_STATUS, rdVal);
      chk({7'h00, rdVal[6]}, 8'h00);
      chk({7'h00, oscEn[1]}, 8'h01);
      // Monitor alone must also keep LF alive
      @(posedge clk);
      wdtEnable <= 1'b0;
      fsmEnable <= 1'b1;
      repeat (3) @(posedge clk);
      #1;
      chk({7'h00, oscEn[0]}, 8'h01);
      endTest("lf");

      // Pin roles in and out of internal mode
      @(posedge clk);
      gpioOsc1 <= '{o: 1'b1, oe: 1'b1};
      gpioOsc2 <= '{o: 1'b0, oe: 1'b1};
      oscInLevel <= 1'b1;
      repeat (3) @(posedge clk);
      #1;
      chk({6'h00, oscInPin}, 8'h03);
      chk({6'h00, oscOutPin}, 8'h01);
      chk({6'h00, pinInData}, 8'h01);
      @(posedge clk);
      clkOutCfg <= 1'b1;
      repeat (3) @(posedge clk);
      #1;
      chk({7'h00, oscOutPin.oe}, 8'h01);
      @(posedge clk);
      cfgOscSelect <= 3'h2;
      wr(ADDR_CTRL, 8'h38);
      repeat (4) @(posedge clk);
      #1;
      chk({7'h00, intActive}, 8'h00);
      chk({7'h00, oscInPin.oe}, 8'h00);
      wr(ADDR_CTRL, 8'h3A);
      repeat (4) @(posedge clk);
      #1;
      chk({7'h00, intActive}, 8'h01);
      endTest("pins");

      // Reset in mid-run restores the registers
      wr(ADDR_TRIM, 8'h05);
      @(posedge clk);
      cfgOscSelect <= FOSC_INTERNAL_BLOCK_CLK;
      wdtEnable <= 1'b0;
      fsmEnable <= 1'b0;
      rst_n <= 1'b0;
      repeat (2) @(posedge clk);
      rst_n <= 1'b1;
      rd(ADDR_CTRL, rdVal);
      chk(rdVal, 8'h38);
      rd(ADDR_TRIM, rdVal);
      chk(rdVal, 8'h00);
      repeat (4) @(posedge clk);
      #1;
      chk({7'h00, intActive}, 8'h01);
      endTest("rerun");
      giveVerdict();
   end
endmodule
